// ==== verilog/tppc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tppc_map.svh"
module tppc_top (
  input  wire logic                              i_mclk,
  input  wire logic                              i_resetn,
  input  wire logic                              i_tms_pin,
  input  wire logic                              i_tck_pin,
  input  wire logic                              i_tdi_pin,
  input  wire logic                              i_tdo_pin,
  output var  tppc_pkg::tppc_pad_type            o_tck_pad,
  output var  tppc_pkg::tppc_pad_type            o_tdi_pad,
  output var  tppc_pkg::tppc_pad_type            o_tdo_pad,
  input  wire logic                              i_dedicated_test,
  input  wire logic                              i_probe_fuse,
  input  wire logic                              i_probe_lock,
  input  wire logic                              i_probe_a_pin,
  input  wire logic                              i_probe_b_pin,
  output var  tppc_pkg::tppc_pad_type            o_probe_a_pin,
  output var  tppc_pkg::tppc_pad_type            o_probe_b_pin,
  input  wire logic [`TPPC_N_NODE-1:0]           i_node,
  input  wire logic [2:0]                        i_user_scan_out,
  input  wire logic [2:0]                        i_user_scan_oe,
  output logic      [2:0]                        o_user_scan_in,
  input  wire logic [1:0]                        i_user_probe_out,
  input  wire logic [1:0]                        i_user_probe_oe,
  output logic      [1:0]                        o_user_probe_in,
  input  wire logic                              i_hclk_pin,
  input  wire logic                              i_routed_clock_a,
  input  wire logic                              i_routed_clock_b,
  output logic                                   o_hard_clk_en,
  output logic      [1:0]                        o_routed_clk_en,
  input  wire logic [`TPPC_N_GPIO-1:0]           i_gpio_pin,
  input  wire tppc_pkg::tppc_pin_mode_type [`TPPC_N_GPIO-1:0] i_gpio_mode,
  input  wire logic [`TPPC_N_GPIO-1:0]           i_gpio_out,
  input  wire logic [`TPPC_N_GPIO-1:0]           i_gpio_oe,
  output var  tppc_pkg::tppc_pad_type [`TPPC_N_GPIO-1:0] o_gpio_pad,
  output logic      [`TPPC_N_GPIO-1:0]           o_gpio_in,
  output logic                                   o_test_active,
  output logic                                   o_probe_locked
);

  tppc_pkg::tppc_state_type     st;
  tppc_pkg::tppc_state_type     next_st;
  tppc_pkg::tppc_tap_state_type tap_state;
  logic                         tap_enter_reset;
  logic                         tms_s;
  logic                         tdi_s;
  logic                         ded_s;
  logic                         fuse_s;
  logic                         tck_rise;
  logic                         tck_fall;
  logic                         tap_run;
  logic                         test_use;
  logic                         hclk_rise;
  logic [1:0]                   rclk_rise;
  logic [1:0]                   probe_on;
  logic                         node_a;
  logic                         node_b;
  logic [`TPPC_N_GPIO-1:0]      gpio_oe_n;
  logic [`TPPC_N_GPIO-1:0]      gpio_in_n;

  // ============================================================
  // Pin sampling
  // All pin levels are read from the second synchroniser stage only; the
  // third stage of the clock pins exists purely for edge detection.
  assign tms_s     = st.syn2[`TPPC_SYN_TMS];
  assign tdi_s     = st.syn2[`TPPC_SYN_TDI];
  assign ded_s     = st.syn2[`TPPC_SYN_DED];
  assign fuse_s    = st.syn2[`TPPC_SYN_FUSE];
  assign tck_rise  = st.syn2[`TPPC_SYN_TCK] && !st.tck_prev;
  assign tck_fall  = !st.syn2[`TPPC_SYN_TCK] && st.tck_prev;
  assign hclk_rise = st.syn2[`TPPC_SYN_HCLK] && !st.hclk_prev;
  assign rclk_rise = st.syn2[`TPPC_SYN_RCB:`TPPC_SYN_RCA] & ~st.rclk_prev;

  // The scan state machine only runs while the scan pins are in test use,
  // so user traffic on the shared clock pin cannot walk it out of reset.
  assign tap_run  = ded_s || st.active;
  assign test_use = tap_run;

  tppc_tap u_tap (
    .i_mclk        (i_mclk),
    .i_resetn      (i_resetn),
    .i_step        (tck_rise && tap_run),
    .i_tms         (tms_s),
    .i_force_reset (!tap_run),
    .o_state       (tap_state),
    .o_enter_reset (tap_enter_reset)
  );

  // ============================================================
  // Probe selection
  assign probe_on[0] = st.cfg.en_a && !st.locked && !fuse_s;
  assign probe_on[1] = st.cfg.en_b && !st.locked && !fuse_s;
  assign node_a      = i_node[st.cfg.sel_a];
  assign node_b      = i_node[st.cfg.sel_b];

  // ============================================================
  // General-purpose pin buffers
  genvar g;
  generate
    for (g = 0; g < `TPPC_N_GPIO; g = g + 1) begin : gen_gpio
      assign gpio_oe_n[g] = (i_gpio_mode[g] == tppc_pkg::pin_output) ||
                            (((i_gpio_mode[g] == tppc_pkg::pin_tristate) ||
                              (i_gpio_mode[g] == tppc_pkg::pin_bidir)) && i_gpio_oe[g]);
      assign gpio_in_n[g] = ((i_gpio_mode[g] == tppc_pkg::pin_input) ||
                             (i_gpio_mode[g] == tppc_pkg::pin_bidir)) &&
                            st.syn2[`TPPC_SYN_GPIO+g];

      AST_GPIO_MODE: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        (i_gpio_mode[g] == tppc_pkg::pin_input) |=> !o_gpio_pad[g].oe && o_gpio_pad[g].out == $past(i_gpio_out[g]))
        else $error("input-mode pin is driving");
    end
  endgenerate

  // ============================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.syn1 = {i_gpio_pin, i_routed_clock_b, i_routed_clock_a, i_hclk_pin, i_probe_b_pin,
                    i_probe_a_pin, i_probe_fuse, i_dedicated_test, i_tdo_pin, i_tdi_pin,
                    i_tck_pin, i_tms_pin};
    next_st.syn2      = st.syn1;
    next_st.tck_prev  = st.syn2[`TPPC_SYN_TCK];
    next_st.hclk_prev = st.syn2[`TPPC_SYN_HCLK];
    next_st.rclk_prev = st.syn2[`TPPC_SYN_RCB:`TPPC_SYN_RCA];

    // Hardwired clock enable goes straight to the cells; routed clocks pay
    // one extra buffer stage, which is why they arrive a cycle later.
    next_st.hard_en   = hclk_rise;
    next_st.rclk_buf  = rclk_rise;
    next_st.routed_en = st.rclk_buf;

    // Flexible-mode ownership of the scan pins.
    if (!ded_s) begin
      if (!st.active && !tms_s) begin
        next_st.active = 1'b1;
      end else if (st.active && tap_enter_reset) begin
        next_st.active = 1'b0;
      end
    end

    // Scan shifting on test clock rises.
    if (tck_rise && tap_run) begin
      case (tap_state)
        tppc_pkg::tap_cap_ir: next_st.ir_sh = `TPPC_IR_CAPTURE;
        tppc_pkg::tap_sh_ir:  next_st.ir_sh = {tdi_s, st.ir_sh[`TPPC_IR_W-1:1]};
        tppc_pkg::tap_cap_dr: begin
          next_st.dr_sh = st.cfg;
          next_st.byp   = 1'b0;
        end
        tppc_pkg::tap_sh_dr: begin
          if (st.ir == `TPPC_OP_PROBE) begin
            next_st.dr_sh = {tdi_s, st.dr_sh[`TPPC_DR_W-1:1]};
          end else begin
            next_st.byp = tdi_s;
          end
        end
        default: next_st.byp = st.byp;
      endcase
    end

    // Output and update actions on test clock falls.
    if (tck_fall && tap_run) begin
      case (tap_state)
        tppc_pkg::tap_sh_ir: next_st.tdo = st.ir_sh[0];
        tppc_pkg::tap_sh_dr: next_st.tdo = (st.ir == `TPPC_OP_PROBE) ? st.dr_sh[0] : st.byp;
        tppc_pkg::tap_upd_ir: next_st.ir = st.ir_sh;
        tppc_pkg::tap_upd_dr: begin
          if (st.ir == `TPPC_OP_PROBE) begin
            next_st.cfg = st.dr_sh;
          end
        end
        default: next_st.tdo = st.tdo;
      endcase
    end
    if (tap_state == tppc_pkg::tap_reset) begin
      next_st.ir = `TPPC_OP_BYPASS;
    end

    // Lock is sticky until power-on reset; the fuse input covers the
    // permanent case across resets.
    if (i_probe_lock || fuse_s) begin
      next_st.locked = 1'b1;
    end

    // Scan pins: clock and data-in are inputs in test use, data-out drives
    // only while shifting.
    if (test_use) begin
      next_st.scan_pad[0]  = '{out: 1'b0, oe: 1'b0};
      next_st.scan_pad[1]  = '{out: 1'b0, oe: 1'b0};
      next_st.scan_pad[2]  = '{out: st.tdo,
                               oe: (tap_state == tppc_pkg::tap_sh_dr) ||
                                   (tap_state == tppc_pkg::tap_sh_ir)};
      next_st.user_scan_in = 3'h0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        next_st.scan_pad[k] = '{out: i_user_scan_out[k], oe: i_user_scan_oe[k]};
      end
      next_st.user_scan_in = st.syn2[`TPPC_SYN_TDO:`TPPC_SYN_TCK];
    end

    // Probe pins.
    if (probe_on[0]) begin
      next_st.probe_pad[0] = '{out: node_a, oe: 1'b1};
    end else begin
      next_st.probe_pad[0] = '{out: i_user_probe_out[0], oe: i_user_probe_oe[0]};
    end
    if (probe_on[1]) begin
      next_st.probe_pad[1] = '{out: node_b, oe: 1'b1};
    end else begin
      next_st.probe_pad[1] = '{out: i_user_probe_out[1], oe: i_user_probe_oe[1]};
    end
    next_st.user_probe_in = st.syn2[`TPPC_SYN_PROBE_B:`TPPC_SYN_PROBE_A];

    for (int k = 0; k < `TPPC_N_GPIO; k++) begin
      next_st.gpio_pad[k] = '{out: i_gpio_out[k], oe: gpio_oe_n[k]};
    end
    next_st.gpio_in = gpio_in_n;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st    <= '0;
      st.ir <= `TPPC_OP_BYPASS;
      // Test mode select idles high; a low reset value here would make the
      // first cycles after reset look like a claim of the scan pins.
      st.syn1[`TPPC_SYN_TMS] <= 1'b1;
      st.syn2[`TPPC_SYN_TMS] <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ============================================================
  // Outputs
  assign o_tck_pad       = st.scan_pad[0];
  assign o_tdi_pad       = st.scan_pad[1];
  assign o_tdo_pad       = st.scan_pad[2];
  assign o_user_scan_in  = st.user_scan_in;
  assign o_probe_a_pin   = st.probe_pad[0];
  assign o_probe_b_pin   = st.probe_pad[1];
  assign o_user_probe_in = st.user_probe_in;
  assign o_hard_clk_en   = st.hard_en;
  assign o_routed_clk_en = st.routed_en;
  assign o_gpio_pad      = st.gpio_pad;
  assign o_gpio_in       = st.gpio_in;
  assign o_test_active   = test_use;
  assign o_probe_locked  = st.locked;

  // ============================================================
  // Checks
  AST_FLEX_ENTER: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (!ded_s && !st.active && !tms_s) |=> st.active ##1 (!o_tck_pad.oe && !o_tdi_pad.oe))
    else $error("low TMS did not claim the scan pins");

  AST_FLEX_HOLD: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (st.active && !tap_enter_reset) |=> st.active)
    else $error("scan pins released before scan reset");

  AST_FLEX_FREE: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (!ded_s && st.active && tap_enter_reset) |=> !st.active ##1
    (o_tdo_pad.oe == $past(i_user_scan_oe[2])))
    else $error("scan pins not released at scan reset");

  AST_DED_PINS: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    ded_s |=> (!o_tck_pad.oe && !o_tdi_pad.oe && o_user_scan_in == 3'h0))
    else $error("dedicated test mode fell back to user I/O");

  AST_PROBE_LOAD: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (tck_fall && tap_run && tap_state == tppc_pkg::tap_upd_dr && st.ir == `TPPC_OP_PROBE)
    |=> (st.cfg == $past(st.dr_sh)))
    else $error("probe selection not loaded from scan data");

  AST_PROBE_LIVE: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    probe_on[0] |=> (o_probe_a_pin.oe && o_probe_a_pin.out == $past(node_a)))
    else $error("probe A does not show the selected node");

  AST_PROBE_USER: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    !probe_on[1] |=> (o_probe_b_pin.out == $past(i_user_probe_out[1]) &&
                      o_probe_b_pin.oe == $past(i_user_probe_oe[1])))
    else $error("idle probe B not under user control");

  AST_LOCK_STAYS: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    st.locked |=> st.locked && !probe_on[1] &&
                  (o_probe_a_pin.out == $past(i_user_probe_out[0])) &&
                  (o_probe_a_pin.oe == $past(i_user_probe_oe[0])))
    else $error("probe lock lost or probing still possible");

  AST_HARD_CLK: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    hclk_rise |=> o_hard_clk_en)
    else $error("hardwired clock edge not delivered next cycle");

  AST_ROUTED_CLK: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    rclk_rise[0] |=> !o_routed_clk_en[0] ##1 o_routed_clk_en[0])
    else $error("routed clock A skipped its buffer stage");

endmodule : tppc_top
`default_nettype wire

// ==== verilog/tppc_map.svh ====
// Overview of operation
// - In flexible mode a low test mode select hands the test clock, data-in and data-out pins to scan use.
// - Once in scan use the pins stay there until the scan state machine enters its reset state, then return to user I/O.
// - Five test clock cycles with test mode select high bring the scan state machine to reset; the tester must supply them.
// - In dedicated test mode test mode select acts as the standard scan select and the pins never fall back to user I/O.
// - The data-in pin feeds both scan shifting and probe selection, and the test clock clocks probe operations.
// - Each probe pin can output the live value of any selected internal node, giving real-time diagnosis with both.
// - A probe pin not in probe use is an ordinary user input or output driven by the design.
// - Probing can be disabled permanently on both probe pins, after which no node is visible there.
// - The hardwired array clock reaches every register cell directly, with no dependence on fan-out.
// - The two routed clock inputs pass a buffer stage before they clock the register cells.
// - Each general-purpose pin can be an input, an output, a tristate output or a bidirectional buffer.
`ifndef TPPC_MAP_SVH
`define TPPC_MAP_SVH

// ============================================================
// Sizes
`define TPPC_N_GPIO        4
`define TPPC_N_NODE        16
`define TPPC_SEL_W         4
`define TPPC_IR_W          4
`define TPPC_DR_W          10
`define TPPC_TLR_TMS_TCKS  5

// ============================================================
// Instruction codes and capture value
`define TPPC_OP_BYPASS     4'hf
`define TPPC_OP_PROBE      4'h2
`define TPPC_IR_CAPTURE    4'h1

// ============================================================
// Pin synchroniser layout
`define TPPC_SYNC_W        15
`define TPPC_SYN_TMS       0
`define TPPC_SYN_TCK       1
`define TPPC_SYN_TDI       2
`define TPPC_SYN_TDO       3
`define TPPC_SYN_DED       4
`define TPPC_SYN_FUSE      5
`define TPPC_SYN_PROBE_A   6
`define TPPC_SYN_PROBE_B   7
`define TPPC_SYN_HCLK      8
`define TPPC_SYN_RCA       9
`define TPPC_SYN_RCB       10
`define TPPC_SYN_GPIO      11

`endif

// ==== verilog/tppc_pkg.sv ====
`default_nettype none
`include "tppc_map.svh"
package tppc_pkg;

  typedef enum logic [3:0] {
    tap_reset, tap_idle, tap_sel_dr, tap_cap_dr, tap_sh_dr, tap_ex1_dr, tap_pa_dr, tap_ex2_dr,
    tap_upd_dr, tap_sel_ir, tap_cap_ir, tap_sh_ir, tap_ex1_ir, tap_pa_ir, tap_ex2_ir, tap_upd_ir
  } tppc_tap_state_type;

  typedef enum logic [1:0] {
    pin_input, pin_output, pin_tristate, pin_bidir
  } tppc_pin_mode_type;

  typedef struct packed {
    logic out;
    logic oe;
  } tppc_pad_type;

  typedef struct packed {
    logic                    en_b;
    logic                    en_a;
    logic [`TPPC_SEL_W-1:0]  sel_b;
    logic [`TPPC_SEL_W-1:0]  sel_a;
  } tppc_probe_cfg_type;

  typedef struct packed {
    tppc_tap_state_type state;
    logic [2:0]         tms_high_cnt;
  } tppc_tap_reg_type;

  typedef struct packed {
    logic [`TPPC_SYNC_W-1:0]    syn1;
    logic [`TPPC_SYNC_W-1:0]    syn2;
    logic                       tck_prev;
    logic                       hclk_prev;
    logic [1:0]                 rclk_prev;
    logic                       hard_en;
    logic [1:0]                 rclk_buf;
    logic [1:0]                 routed_en;
    logic                       active;
    logic [`TPPC_IR_W-1:0]      ir;
    logic [`TPPC_IR_W-1:0]      ir_sh;
    logic [`TPPC_DR_W-1:0]      dr_sh;
    logic                       byp;
    logic                       tdo;
    tppc_probe_cfg_type         cfg;
    logic                       locked;
    tppc_pad_type [2:0]         scan_pad;
    logic [2:0]                 user_scan_in;
    tppc_pad_type [1:0]         probe_pad;
    logic [1:0]                 user_probe_in;
    tppc_pad_type [`TPPC_N_GPIO-1:0] gpio_pad;
    logic [`TPPC_N_GPIO-1:0]    gpio_in;
  } tppc_state_type;

endpackage : tppc_pkg
`default_nettype wire

// ==== verilog/tppc_tap.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tppc_map.svh"
module tppc_tap (
  input  wire logic                     i_mclk,
  input  wire logic                     i_resetn,
  input  wire logic                     i_step,
  input  wire logic                     i_tms,
  input  wire logic                     i_force_reset,
  output var  tppc_pkg::tppc_tap_state_type o_state,
  output logic                          o_enter_reset
);

  tppc_pkg::tppc_tap_reg_type st;
  tppc_pkg::tppc_tap_reg_type next_st;
  tppc_pkg::tppc_tap_state_type nxt;

  // ============================================================
  // Standard test access port sequence
  always_comb begin
    nxt = st.state;
    case (st.state)
      tppc_pkg::tap_reset:  nxt = i_tms ? tppc_pkg::tap_reset  : tppc_pkg::tap_idle;
      tppc_pkg::tap_idle:   nxt = i_tms ? tppc_pkg::tap_sel_dr : tppc_pkg::tap_idle;
      tppc_pkg::tap_sel_dr: nxt = i_tms ? tppc_pkg::tap_sel_ir : tppc_pkg::tap_cap_dr;
      tppc_pkg::tap_cap_dr: nxt = i_tms ? tppc_pkg::tap_ex1_dr : tppc_pkg::tap_sh_dr;
      tppc_pkg::tap_sh_dr:  nxt = i_tms ? tppc_pkg::tap_ex1_dr : tppc_pkg::tap_sh_dr;
      tppc_pkg::tap_ex1_dr: nxt = i_tms ? tppc_pkg::tap_upd_dr : tppc_pkg::tap_pa_dr;
      tppc_pkg::tap_pa_dr:  nxt = i_tms ? tppc_pkg::tap_ex2_dr : tppc_pkg::tap_pa_dr;
      tppc_pkg::tap_ex2_dr: nxt = i_tms ? tppc_pkg::tap_upd_dr : tppc_pkg::tap_sh_dr;
      tppc_pkg::tap_upd_dr: nxt = i_tms ? tppc_pkg::tap_sel_dr : tppc_pkg::tap_idle;
      tppc_pkg::tap_sel_ir: nxt = i_tms ? tppc_pkg::tap_reset  : tppc_pkg::tap_cap_ir;
      tppc_pkg::tap_cap_ir: nxt = i_tms ? tppc_pkg::tap_ex1_ir : tppc_pkg::tap_sh_ir;
      tppc_pkg::tap_sh_ir:  nxt = i_tms ? tppc_pkg::tap_ex1_ir : tppc_pkg::tap_sh_ir;
      tppc_pkg::tap_ex1_ir: nxt = i_tms ? tppc_pkg::tap_upd_ir : tppc_pkg::tap_pa_ir;
      tppc_pkg::tap_pa_ir:  nxt = i_tms ? tppc_pkg::tap_ex2_ir : tppc_pkg::tap_pa_ir;
      tppc_pkg::tap_ex2_ir: nxt = i_tms ? tppc_pkg::tap_upd_ir : tppc_pkg::tap_sh_ir;
      tppc_pkg::tap_upd_ir: nxt = i_tms ? tppc_pkg::tap_sel_dr : tppc_pkg::tap_idle;
      default:              nxt = tppc_pkg::tap_reset;
    endcase
  end

  always_comb begin
    next_st = st;
    o_enter_reset = 1'b0;
    if (i_force_reset) begin
      next_st.state = tppc_pkg::tap_reset;
      next_st.tms_high_cnt = 3'h0;
    end else if (i_step) begin
      next_st.state = nxt;
      o_enter_reset = (nxt == tppc_pkg::tap_reset) && (st.state != tppc_pkg::tap_reset);
      if (!i_tms) begin
        next_st.tms_high_cnt = 3'h0;
      end else if (st.tms_high_cnt != 3'h7) begin
        next_st.tms_high_cnt = st.tms_high_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_state = st.state;

  // ============================================================
  // Checks
  AST_TLR_FIVE: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    (st.tms_high_cnt >= 3'(`TPPC_TLR_TMS_TCKS)) |-> (st.state == tppc_pkg::tap_reset))
    else $error("scan state machine not in reset after five high TMS clocks");

  AST_TAP_HELD: assert property (
    @(posedge i_mclk) disable iff (!i_resetn)
    i_force_reset |=> (st.state == tppc_pkg::tap_reset) && !o_enter_reset)
    else $error("idle scan state machine left test-logic-reset");

endmodule : tppc_tap
`default_nettype wire

// ==== verification/tppc_tester.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Scan tester
module tppc_tester (
  input  wire logic i_tdo,
  output var  logic o_tms,
  output var  logic o_tck,
  output var  logic o_tdi
);
  initial begin
    o_tms = 1'h1;
    o_tck = 1'h0;
    o_tdi = 1'h0;
  end
  // One 320 ns link cycle; the clock rests low between cycles.
  // Data out is taken mid high phase, well after the last falling edge.
  task step(input logic tms, input logic tdi, output logic tdo);
    #7 o_tms = tms;
    o_tdi = tdi;
    #153 o_tck = 1'h1;
    #80 tdo = i_tdo;
    #80 o_tck = 1'h0;
  endtask : step
  // Shifts n bits, first bit first, and leaves the state machine in exit.
  task shift(input logic [9:0] din, input int n, output logic [9:0] dout);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
  endtask : shift
endmodule : tppc_tester
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    tppc_pkg::tppc_pin_mode_type m;
    logic [3:0]                  oe;
    logic [3:0]                  din;
  } tppc_row_type;
  localparam tppc_row_type rows [4] = '{
    '{tppc_pkg::pin_input, 4'h0, 4'ha}, '{tppc_pkg::pin_output, 4'hf, 4'h0},
    '{tppc_pkg::pin_tristate, 4'h3, 4'h0}, '{tppc_pkg::pin_bidir, 4'h3, 4'ha}};
  logic i_mclk, i_resetn, i_tms_pin, i_tck_pin, i_tdi_pin, i_tdo_pin, i_dedicated_test;
  logic i_probe_fuse, i_probe_lock, i_probe_a_pin, i_probe_b_pin, i_hclk_pin;
  logic i_routed_clock_a, i_routed_clock_b, o_hard_clk_en, o_test_active, o_probe_locked;
  tppc_pkg::tppc_pad_type o_tck_pad, o_tdi_pad, o_tdo_pad, o_probe_a_pin, o_probe_b_pin;
  logic [15:0] i_node;
  logic [2:0]  i_user_scan_out, i_user_scan_oe, o_user_scan_in;
  logic [1:0]  i_user_probe_out, i_user_probe_oe, o_user_probe_in, o_routed_clk_en;
  logic [3:0]  i_gpio_pin, i_gpio_out, i_gpio_oe, o_gpio_in;
  tppc_pkg::tppc_pin_mode_type [3:0] i_gpio_mode;
  tppc_pkg::tppc_pad_type [3:0]      o_gpio_pad;
  int err_count = 0;
  int n_tests = 0;
  // The data-out line is pulled up whenever the device lets go of it.
  assign i_tdo_pin = o_tdo_pad.oe ? o_tdo_pad.out : 1'h1;
  tppc_top i_tppc_top (.*);
  tppc_tester i_tppc_tester (
    .i_tdo (i_tdo_pin),
    .o_tms (i_tms_pin),
    .o_tck (i_tck_pin),
    .o_tdi (i_tdi_pin)
  );
  initial i_mclk = 1'h0;
  always #20 i_mclk = ~i_mclk;
  // ==========
  // Helpers
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task give_verdict();
    $display("%0d comparisons, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick
  task walk(input logic [7:0] tms, input int n);
    logic q;
    for (int i = 0; i < n; i++) i_tppc_tester.step(tms[i], 1'h0, q);
  endtask : walk
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
  // ==========
  // Sequence
  initial begin
    logic [9:0] q;
    {i_resetn, i_dedicated_test, i_probe_fuse, i_probe_lock, i_hclk_pin} = '0;
    {i_routed_clock_a, i_routed_clock_b, i_probe_a_pin, i_probe_b_pin} = '0;
    {i_node, i_user_scan_out, i_user_scan_oe} = {16'h0008, 3'h5, 3'h7};
    {i_user_probe_out, i_user_probe_oe, i_gpio_pin} = {2'h2, 2'h3, 4'ha};
    {i_gpio_out, i_gpio_oe} = {4'h5, 4'h3};
    i_gpio_mode = '{default: tppc_pkg::pin_input};
    tick(8);
    i_resetn = 1'h1;
    tick(4);
    chk({o_test_active, o_probe_locked, o_tck_pad.oe, o_hard_clk_en}, 4'h2);
    foreach (rows[r]) begin
      i_gpio_mode = '{default: rows[r].m};
      tick(4);
      for (int b = 0; b < 4; b++) chk(o_gpio_pad[b].oe, rows[r].oe[b]);
      if (rows[r].oe[0]) chk(o_gpio_pad[0].out, 1'h1);
      chk(o_gpio_in, rows[r].din);
    end
    chk(o_probe_b_pin, {i_user_probe_out[1], i_user_probe_oe[1]});
    $display("reset and pin modes done");
    walk(8'h00, 1);
    chk({o_test_active, o_tck_pad.oe, o_tdi_pad.oe}, 3'h4);
    walk(8'h01, 3);
    chk(o_tdo_pad.oe, 1'h1);
    walk(8'h0f, 4);
    chk(o_test_active, 1'h1);
    walk(8'h01, 1);
    tick(3);
    chk({o_test_active, o_tck_pad}, {1'h0, i_user_scan_out[0], i_user_scan_oe[0]});
    $display("claim and release done");
    walk(8'h06, 5);
    i_tppc_tester.shift(10'h002, 4, q);
    chk(q[3:0], 4'h1);
    walk(8'h01, 2);
    walk(8'h01, 3);
    i_tppc_tester.shift(10'h353, 10, q);
    chk(q, 10'h000);
    walk(8'h01, 2);
    tick(2);
    chk({o_probe_a_pin, o_probe_b_pin}, 4'hd);
    i_node = 16'h0020;
    tick(2);
    chk({o_probe_a_pin, o_probe_b_pin}, 4'h7);
    i_probe_lock = 1'h1;
    tick(1);
    i_probe_lock = 1'h0;
    tick(2);
    chk({o_probe_locked, o_probe_a_pin, o_probe_b_pin}, {1'h1, i_user_probe_out[0],
        i_user_probe_oe[0], i_user_probe_out[1], i_user_probe_oe[1]});
    $display("probe select and lock done");
    i_dedicated_test = 1'h1;
    walk(8'h1f, 5);
    tick(3);
    chk({o_test_active, o_tck_pad.oe, o_user_scan_in}, 5'h10);
    $display("dedicated mode done");
    i_hclk_pin = 1'h1;
    i_routed_clock_a = 1'h1;
    for (int k = 0; k < 10 && o_hard_clk_en !== 1'h1; k++) tick(1);
    chk({o_hard_clk_en, o_routed_clk_en}, 3'h4);
    tick(1);
    chk({o_hard_clk_en, o_routed_clk_en}, 3'h1);
    $display("clock paths done");
    i_resetn = 1'h0;
    {i_dedicated_test, i_probe_fuse, i_probe_a_pin} = 3'h3;
    tick(2);
    chk({o_probe_locked, o_test_active, o_tck_pad, o_probe_a_pin}, 6'h00);
    i_resetn = 1'h1;
    tick(4);
    chk({o_probe_locked, o_test_active}, 2'h2);
    chk({o_user_probe_in, o_tdi_pad, o_user_scan_in}, 7'h2c);
    $display("mid-run reset and fuse done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
